/* File: logic/dc_pkg.sv */
// constants, types and register map of the dma channel 0 control block
// assumes an axi4-lite master with 32-bit data; registers sit at word index * 4
package dc_pkg;
	localparam int AXI_AW = 10;
	// register index; byte address is index * 4
	localparam logic [7:0] IDX_MAR_A = 8'h20;
	localparam logic [7:0] IDX_CNT_A = 8'h24;
	localparam logic [7:0] IDX_IOA_A = 8'h26;
	localparam logic [7:0] IDX_CTRL_A = 8'h27;
	localparam logic [7:0] IDX_MAR_B = 8'h28;
	localparam logic [7:0] IDX_CNT_B = 8'h2c;
	localparam logic [7:0] IDX_IOA_B = 8'h2e;
	localparam logic [7:0] IDX_CTRL_B = 8'h2f;
	// control field positions
	localparam int B_EN = 7;
	localparam int B_SZ = 6;
	localparam int B_DIR = 5;
	localparam int B_RPT = 4;
	localparam int B_STEP = 4;
	localparam int B_IE = 3;
	localparam int B_BLK = 3;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [7:0] IOA_RST = 8'h00;
	localparam logic [23:0] MAR_RST = 24'h000000;
	localparam logic [15:0] IO_HI = 16'h0000;
	// activation codes
	localparam logic [2:0] SEL_TXE = 3'h4;
	localparam logic [2:0] SEL_RXF = 3'h5;
	localparam logic [2:0] SEL_FALL = 3'h6;
	localparam logic [2:0] SEL_LOW = 3'h7;
	localparam logic [2:0] SEL_AUTO_BURST = 3'h0;
	localparam logic [2:0] SEL_AUTO_STEAL = 3'h2;
	localparam logic [1:0] FULL_CODE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		MODE_IO = 3'h1,
		MODE_RPT = 3'h2,
		MODE_IDLE = 3'h4
	} dc_mode_t;
	typedef struct packed {
		logic [23:0] addr;
		logic [23:0] addr2;
		logic word;
		logic full;
	} dc_xfer_t;
endpackage

/* File: logic/dc_dma_chan0.sv */
// one two-sub-channel dma channel: control, count, address registers
// and the per-transfer stepping, behind an axi4-lite slave.
// assumes timer and serial events are one-cycle pulses on sys_clk_i;
// the external request pin is asynchronous.
// Functional notes
// R1: short mode A select 000-011 timer 0-3, 100 tx-empty, 101 rx-full.
// R2: A select 110 or 111 joins A and B into one full address mode.
// R3: B decodes 000-101 like A; 110 pin falling edge, 111 pin low.
// R4: with irq enable set, request interrupt while transfer enable is clear.
// R5: repeat 0 gives I/O mode; repeat 1 gives repeat or idle by irq enable.
// R6: short mode address steps up or down, by 1 byte or 2 word.
// R7: no transfer nor activation accepted while transfer enable is clear.
// R8: full mode source address fixed unless step enabled, then steps by size.
// R9: B count is 16-bit counter; repeat uses high counter, low initial.
// R10: full mode B count unused normally, block counter in block mode.
// R11: B I/O address gives low address bits in short mode only.
// R12: repeat counter hitting zero reloads count and address, stays enabled.
// R13: I/O and idle decrement count, clear enable when it reaches zero.
`timescale 1ns/1ps
`default_nettype none
module dc_dma_chan0
	import dc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// axi4-lite slave
	input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [AXI_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// activation sources
	input wire logic [3:0] timer_evt_i,
	input wire logic ser_txe_i,
	input wire logic ser_rxf_i,
	input wire logic ext_req_n_i,
	// transfers and interrupts, index 0 is A, 1 is B
	output logic [1:0] xfer_vld_o,
	output dc_xfer_t [1:0] xfer_o,
	output logic [1:0] irq_o
);
	logic [7:0] ctrl_ff [2];
	logic [15:0] cnt_ff [2];
	logic [23:0] mar_ff [2];
	logic [23:0] mar_init_ff [2];
	logic [7:0] ioa_ff [2];
	logic aw_hold_ff, w_hold_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [7:0] awidx_ff;
	logic [31:0] wdata_ff, rdata_ff, nxt_rdata;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff, nxt_rresp;
	logic req_s1_ff, req_s2_ff, req_s3_ff;
	logic req_fall, req_low, full, wr_do, wr_hit;
	logic [7:0] rd_idx;
	logic [1:0] xvld_ff, irq_ff;
	dc_xfer_t [1:0] xfer_ff;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				r[k*8 +: 8] = nw[k*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic dc_mode_t mode_of(input logic [7:0] c);
		if (!c[B_RPT]) begin // R5
			return MODE_IO;
		end
		if (c[B_IE]) begin // R5
			return MODE_IDLE;
		end
		return MODE_RPT; // R5
	endfunction

	function automatic logic [23:0] stepped(input logic [23:0] a, input logic dn,
		input logic word);
		logic [23:0] s;
		s = word ? 24'h000002 : 24'h000001;
		return dn ? a - s : a + s;
	endfunction

	// pin synchroniser; third stage only for edge detection
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_s1_ff <= 1'b1;
			req_s2_ff <= 1'b1;
			req_s3_ff <= 1'b1;
		end else begin
			req_s1_ff <= ext_req_n_i;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
		end
	end
	assign req_fall = req_s3_ff & ~req_s2_ff;
	assign req_low = ~req_s2_ff;
	assign full = ctrl_ff[0][2:1] == FULL_CODE; // R2

	// write channel: address and data taken in either order
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			awready_ff <= 1'b0;
			aw_hold_ff <= 1'b0;
			awidx_ff <= 8'h00;
		end else begin
			if (awready_ff && s_axi_awvalid_i) begin
				awready_ff <= 1'b0;
				aw_hold_ff <= 1'b1;
				awidx_ff <= s_axi_awaddr_i[9:2];
			end else if (!aw_hold_ff && !awready_ff) begin
				awready_ff <= 1'b1;
			end
			if (bvalid_ff && s_axi_bready_i) begin
				aw_hold_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wready_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (wready_ff && s_axi_wvalid_i) begin
				wready_ff <= 1'b0;
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata_i;
				wstrb_ff <= s_axi_wstrb_i;
			end else if (!w_hold_ff && !wready_ff) begin
				wready_ff <= 1'b1;
			end
			if (bvalid_ff && s_axi_bready_i) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	assign wr_do = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign wr_hit = awidx_ff inside {IDX_MAR_A, IDX_CNT_A, IDX_IOA_A, IDX_CTRL_A,
		IDX_MAR_B, IDX_CNT_B, IDX_IOA_B, IDX_CTRL_B};

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_do) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read channel: one cycle from address to data
	assign rd_idx = s_axi_araddr_i[9:2];
	always_comb begin
		nxt_rdata = 32'h00000000;
		nxt_rresp = RESP_OKAY;
		case (rd_idx)
			IDX_MAR_A: nxt_rdata = {8'h00, mar_ff[0]};
			IDX_CNT_A: nxt_rdata = {16'h0000, cnt_ff[0]};
			IDX_IOA_A: nxt_rdata = {24'h000000, ioa_ff[0]};
			IDX_CTRL_A: nxt_rdata = {24'h000000, ctrl_ff[0]};
			IDX_MAR_B: nxt_rdata = {8'h00, mar_ff[1]};
			IDX_CNT_B: nxt_rdata = {16'h0000, cnt_ff[1]};
			IDX_IOA_B: nxt_rdata = {24'h000000, ioa_ff[1]};
			IDX_CTRL_B: nxt_rdata = {24'h000000, ctrl_ff[1]};
			default: nxt_rresp = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RESP_OKAY;
		end else if (arready_ff && s_axi_arvalid_i) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end else if (rvalid_ff) begin
			if (s_axi_rready_i) begin
				rvalid_ff <= 1'b0;
			end
		end else begin
			arready_ff <= 1'b1;
		end
	end

	// per sub-channel engine
	for (genvar i = 0; i < 2; i++) begin : g_sub
		localparam logic [7:0] I_MAR = i == 0 ? IDX_MAR_A : IDX_MAR_B;
		localparam logic [7:0] I_CNT = i == 0 ? IDX_CNT_A : IDX_CNT_B;
		localparam logic [7:0] I_IOA = i == 0 ? IDX_IOA_A : IDX_IOA_B;
		localparam logic [7:0] I_CTRL = i == 0 ? IDX_CTRL_A : IDX_CTRL_B;
		logic trig, go_s, go_f, zero, reload, blk;
		logic [2:0] sel;
		logic [31:0] wv_cnt, wv_mar;
		dc_mode_t mode;

		assign sel = ctrl_ff[i][2:0];
		assign mode = mode_of(ctrl_ff[i]);
		assign blk = ctrl_ff[1][B_BLK];
		assign wv_cnt = merge({16'h0000, cnt_ff[i]}, wdata_ff, wstrb_ff);
		assign wv_mar = merge({8'h00, mar_ff[i]}, wdata_ff, wstrb_ff);

		always_comb begin
			trig = 1'b0;
			if (i == 0 && full) begin
				case (ctrl_ff[1][2:0])
					SEL_AUTO_BURST, SEL_AUTO_STEAL: trig = blk ? timer_evt_i[ctrl_ff[1][1:0]] : 1'b1;
					3'h1, 3'h3: trig = blk && timer_evt_i[ctrl_ff[1][1:0]];
					SEL_FALL: trig = req_fall; // R3
					SEL_LOW: trig = !blk && req_low;
					default: trig = 1'b0;
				endcase
			end else begin
				case (sel)
					3'h0, 3'h1, 3'h2, 3'h3: trig = timer_evt_i[sel[1:0]]; // R1 R3
					SEL_TXE: trig = ser_txe_i; // R1 R3
					SEL_RXF: trig = ser_rxf_i; // R1 R3
					SEL_FALL: trig = i == 1 && req_fall; // R3
					SEL_LOW: trig = i == 1 && req_low; // R3
					default: trig = 1'b0;
				endcase
			end
		end

		// short mode on A needs A clear of full codes; B idles in full mode
		assign go_s = !full && ctrl_ff[i][B_EN] && trig; // R7
		assign go_f = i == 0 && full && ctrl_ff[0][B_EN] && ctrl_ff[1][B_EN] && trig; // R7
		assign reload = go_s && mode == MODE_RPT && cnt_ff[i][15:8] == 8'h01; // R12
		assign zero = go_s ? (mode != MODE_RPT && cnt_ff[i] == 16'h0001)
			: (go_f && (blk ? cnt_ff[1] : cnt_ff[0]) == 16'h0001); // R13 R10

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				ctrl_ff[i] <= CTRL_RST;
			end else if (wr_do && awidx_ff == I_CTRL && wstrb_ff[0]) begin
				ctrl_ff[i] <= wdata_ff[7:0];
			end else if (zero || (i == 1 && g_sub[0].zero && full)) begin
				ctrl_ff[i][B_EN] <= 1'b0; // R13
			end
		end

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				cnt_ff[i] <= CNT_RST;
			end else if (wr_do && awidx_ff == I_CNT) begin
				cnt_ff[i] <= wv_cnt[15:0];
			end else if (reload) begin
				cnt_ff[i][15:8] <= cnt_ff[i][7:0]; // R12 R9
			end else if (go_s && mode == MODE_RPT) begin
				cnt_ff[i][15:8] <= cnt_ff[i][15:8] - 8'h01; // R9
			end else if (go_s) begin
				cnt_ff[i] <= cnt_ff[i] - 16'h0001; // R9 R13
			end else if (g_sub[0].go_f && (i == 1) == blk) begin
				cnt_ff[i] <= cnt_ff[i] - 16'h0001; // R10
			end
		end

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				mar_ff[i] <= MAR_RST;
				mar_init_ff[i] <= MAR_RST;
			end else if (wr_do && awidx_ff == I_MAR) begin
				mar_ff[i] <= wv_mar[23:0];
				mar_init_ff[i] <= wv_mar[23:0];
			end else if (reload) begin
				mar_ff[i] <= mar_init_ff[i]; // R12
			end else if (go_s) begin
				mar_ff[i] <= stepped(mar_ff[i], ctrl_ff[i][B_DIR], ctrl_ff[i][B_SZ]); // R6
			end else if (g_sub[0].go_f && ctrl_ff[i][B_STEP]) begin
				mar_ff[i] <= stepped(mar_ff[i], ctrl_ff[i][B_DIR], ctrl_ff[0][B_SZ]); // R8
			end
		end

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				ioa_ff[i] <= IOA_RST;
			end else if (wr_do && awidx_ff == I_IOA && wstrb_ff[0]) begin
				ioa_ff[i] <= wdata_ff[7:0];
			end
		end

		// transfer strobe carries the address before stepping
		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				xvld_ff[i] <= 1'b0;
				xfer_ff[i] <= '0;
				irq_ff[i] <= 1'b0;
			end else begin
				xvld_ff[i] <= go_s || go_f;
				xfer_ff[i].addr <= mar_ff[i];
				xfer_ff[i].addr2 <= go_f ? mar_ff[1] : {IO_HI, ioa_ff[i]}; // R11
				xfer_ff[i].word <= ctrl_ff[0][B_SZ] && go_f || ctrl_ff[i][B_SZ] && !go_f;
				xfer_ff[i].full <= go_f;
				// in full mode bit 3 of B selects block transfer, not an irq enable
				irq_ff[i] <= ctrl_ff[i][B_IE] && !ctrl_ff[i][B_EN] && !(i == 1 && full); // R4
			end
		end
	end

	assign s_axi_awready_o = awready_ff;
	assign s_axi_wready_o = wready_ff;
	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o = bresp_ff;
	assign s_axi_arready_o = arready_ff;
	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rdata_o = rdata_ff;
	assign s_axi_rresp_o = rresp_ff;
	assign xfer_vld_o = xvld_ff;
	assign xfer_o = xfer_ff;
	assign irq_o = irq_ff;
endmodule
`default_nettype wire

/* File: testbench/dc_src_model.sv */
// source model: timer, serial and request pin events for the channel
// assumes one clock shared with the channel
`timescale 1ns/1ps
`default_nettype none
module dc_src_model (
	// clock
	input wire logic sys_clk_i,
	// events
	output logic [3:0] timer_evt_o,
	output logic ser_txe_o,
	output logic ser_rxf_o,
	output logic ext_req_n_o
);
	// request pin idles high as if pulled up
	initial begin
		{ser_rxf_o, ser_txe_o, timer_evt_o} = 6'h00;
		ext_req_n_o = 1'h1;
	end
	// one-cycle pulse: 0-3 timers, 4 tx empty, 5 rx full
	task automatic pulse(input int c);
		@(posedge sys_clk_i);
		{ser_rxf_o, ser_txe_o, timer_evt_o} <= 6'h01 << c;
		@(posedge sys_clk_i);
		{ser_rxf_o, ser_txe_o, timer_evt_o} <= 6'h00;
	endtask
	task automatic pin(input logic v);
		@(posedge sys_clk_i);
		ext_req_n_o <= v;
	endtask
endmodule
`default_nettype wire

/* File: testbench/dc_dma_chan0_asserts.sv */
// port-level checker for the dma channel 0 control block
// bound to dc_dma_chan0, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module dc_dma_chan0_asserts
	import dc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// bus
	input wire logic s_axi_bvalid_o,
	// sources
	input wire logic [3:0] timer_evt_i,
	input wire logic ser_txe_i,
	input wire logic ser_rxf_i,
	input wire logic ext_req_n_i,
	// transfers
	input wire logic [1:0] xfer_vld_o,
	input wire dc_xfer_t [1:0] xfer_o,
	input wire logic [1:0] irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	AST_A_SRC: assert property (xfer_vld_o[0] && !xfer_o[0].full |->
		$past(|{timer_evt_i, ser_txe_i, ser_rxf_i})) else $error("a without source");
	AST_B_SRC: assert property (xfer_vld_o[1] |->
		$past(|{timer_evt_i, ser_txe_i, ser_rxf_i}) || !($past(ext_req_n_i) &&
		$past(ext_req_n_i, 2) && $past(ext_req_n_i, 3) && $past(ext_req_n_i, 4)))
		else $error("b without source");
	AST_IO_HIGH: assert property (xfer_vld_o[0] && !xfer_o[0].full |->
		xfer_o[0].addr2[23:8] == 16'h0000) else $error("io address high bits set");
	AST_IO_HIGH_B: assert property (xfer_vld_o[1] |->
		xfer_o[1].addr2[23:8] == 16'h0000) else $error("b io address high bits set");
	AST_FULL_ONE: assert property (xfer_vld_o[0] && xfer_o[0].full |->
		!xfer_vld_o[1]) else $error("b moved in full mode");
	AST_B_SHORT: assert property (xfer_vld_o[1] |-> !xfer_o[1].full)
		else $error("b flagged full");
	AST_IRQ_XFER: assert property ((xfer_vld_o & irq_o) == 2'h0)
		else $error("irq during transfer");
	AST_IRQ_RISE: assert property ($rose(irq_o[1]) |->
		$past(xfer_vld_o[1]) || $past(s_axi_bvalid_o)) else $error("irq rose alone");
	AST_IRQ_FALL: assert property ($fell(irq_o[1]) |-> $past(s_axi_bvalid_o))
		else $error("irq fell alone");
endmodule
bind dc_dma_chan0 dc_dma_chan0_asserts u_chk (.*);
`default_nettype wire

/* File: testbench/dma_channel0_control_bench.sv */
// self-checking bench for the dma channel 0 control block
// drives the axi4-lite slave and the event source model
`timescale 1ns/1ps
`default_nettype none
module dma_channel0_control_bench
	import dc_pkg::*;
;
	logic sys_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [AXI_AW-1:0] s_axi_awaddr_i = 10'h0, s_axi_araddr_i = 10'h0;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i = 4'hf, timer_evt_i;
	logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, ser_txe_i, ser_rxf_i, ext_req_n_i;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, xfer_vld_o, irq_o;
	dc_xfer_t [1:0] xfer_o;
	int fail_count = 0, compares = 0;
	logic [25:0] q0[$], q1[$];
	always #5 sys_clk_i = ~sys_clk_i;
	dc_dma_chan0 DUT (.*);
	dc_src_model u_src (.sys_clk_i(sys_clk_i), .timer_evt_o(timer_evt_i),
		.ser_txe_o(ser_txe_i), .ser_rxf_o(ser_rxf_i), .ext_req_n_o(ext_req_n_i));
	always @(posedge sys_clk_i) begin
		if (xfer_vld_o[0]) q0.push_back({xfer_o[0].word, xfer_o[0].full, xfer_o[0].addr});
		if (xfer_vld_o[1]) q1.push_back({xfer_o[1].word, xfer_o[1].full, xfer_o[1].addr});
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tmo(input int i);
		if (i >= 40) begin
			fail_count++;
			test_done;
		end
	endtask
	task automatic wr(input logic [7:0] x, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		int i;
		@(posedge sys_clk_i);
		s_axi_awaddr_i <= {x, 2'h0};
		s_axi_wdata_i <= d;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		for (i = 0; i < 40; i++) begin
			@(posedge sys_clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
			if (s_axi_bvalid_o) break;
		end
		s_axi_bready_i <= 1'h0;
		tmo(i);
		chk("bresp", s_axi_bresp_o, r);
	endtask
	task automatic rd(input logic [7:0] x, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
		int i;
		@(posedge sys_clk_i);
		s_axi_araddr_i <= {x, 2'h0};
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
		for (i = 0; i < 40; i++) begin
			@(posedge sys_clk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
			if (s_axi_rvalid_o) break;
		end
		s_axi_rready_i <= 1'h0;
		tmo(i);
		chk("rdata", s_axi_rdata_o, e);
		chk("rresp", s_axi_rresp_o, r);
	endtask
	task automatic s_regs;
		rd(IDX_CTRL_A, 32'h0);
		rd(IDX_CTRL_B, 32'h0);
		rd(8'h01, 32'h0, RESP_SLVERR);
		wr(8'h01, 32'hff, RESP_SLVERR);
		wr(IDX_IOA_B, 32'h1a5);
		rd(IDX_IOA_B, 32'ha5);
	endtask
	// size and direction vary with the source code
	task automatic s_srcs;
		for (int c = 0; c < 6; c++) begin
			wr(IDX_MAR_A, 32'h100);
			wr(IDX_CNT_A, 32'h9);
			wr(IDX_CTRL_A, 32'h80 + c + (c & 1) * 64 + (c & 2) * 16);
			q0 = {};
			u_src.pulse((c + 1) % 6);
			repeat (2) u_src.pulse(c);
			repeat (3) @(posedge sys_clk_i);
			chk("a count", q0.size(), 2);
			chk("a addr", q0[0][24:0], 32'h100);
			chk("a word", q0[0][25], c & 1);
			chk("a step", q0[1][24:0], (c & 2) ? 32'hff - (c & 1) : 32'h101 + (c & 1));
		end
	endtask
	task automatic s_io_end;
		wr(IDX_CNT_B, 32'h2);
		wr(IDX_CTRL_B, 32'h8c);
		q1 = {};
		repeat (3) u_src.pulse(4);
		repeat (3) @(posedge sys_clk_i);
		chk("b count", q1.size(), 2);
		chk("b irq", irq_o[1], 1);
		rd(IDX_CTRL_B, 32'h0c);
		rd(IDX_CNT_B, 32'h0);
		wr(IDX_CTRL_B, 32'h04);
		repeat (2) @(posedge sys_clk_i);
		chk("b irq off", irq_o[1], 0);
	endtask
	// repeat reloads after the second transfer, idle keeps counting
	task automatic s_modes;
		for (int m = 0; m < 2; m++) begin
			wr(IDX_CNT_B, 32'h0202);
			wr(IDX_MAR_B, 32'h40);
			wr(IDX_CTRL_B, 32'h91 + m * 8);
			q1 = {};
			repeat (3) u_src.pulse(1);
			repeat (3) @(posedge sys_clk_i);
			chk("mode n", q1.size(), 3);
			chk("mode addr", q1[2], m ? 32'h42 : 32'h40);
			rd(IDX_CTRL_B, 32'h91 + m * 8);
			rd(IDX_CNT_B, m ? 32'h01ff : 32'h0102);
		end
	endtask
	task automatic s_pin;
		wr(IDX_CNT_B, 32'h20);
		for (int l = 0; l < 2; l++) begin
			wr(IDX_CTRL_B, 32'h86 + l);
			q1 = {};
			u_src.pin(1'h0);
			repeat (8) @(posedge sys_clk_i);
			u_src.pin(1'h1);
			repeat (5) @(posedge sys_clk_i);
			chk("b pin", q1.size(), l ? 9 : 1);
		end
	endtask
	task automatic s_full;
		wr(IDX_MAR_A, 32'h300);
		for (int s = 0; s < 2; s++) begin
			wr(IDX_CNT_A, 32'h3);
			wr(IDX_CTRL_B, 32'h80);
			q0 = {};
			q1 = {};
			wr(IDX_CTRL_A, 32'h86 + s * 32'h70);
			repeat (8) @(posedge sys_clk_i);
			chk("full n", q0.size(), 3);
			chk("full addr", q0[2], s ? 32'h30002fc : 32'h1000300);
			chk("full b", q1.size(), 0);
			rd(IDX_CTRL_A, 32'h06 + s * 32'h70);
		end
	endtask
	// block mode: timer 0 paces the pair, count B ends it, count A untouched
	task automatic s_blk;
		wr(IDX_CNT_B, 32'h2);
		wr(IDX_CTRL_B, 32'h88);
		wr(IDX_CTRL_A, 32'h86);
		q0 = {};
		repeat (3) u_src.pulse(0);
		repeat (3) @(posedge sys_clk_i);
		chk("blk n", q0.size(), 2);
		rd(IDX_CNT_B, 32'h0);
		rd(IDX_CNT_A, 32'h0);
		rd(IDX_CTRL_B, 32'h08);
		chk("blk irq", irq_o, 0);
	endtask
	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		s_regs;
		s_srcs;
		s_io_end;
		s_modes;
		s_pin;
		s_full;
		s_blk;
		test_done;
	end
endmodule
`default_nettype wire
